// ---- pkg/epsc_params.svh ----
// Offsets, field positions, codes and timing counts of the power-state block.
// Assumes a 250 MHz clock and a byte-addressed register port.
`ifndef EPSC_PARAMS_SVH
`define EPSC_PARAMS_SVH

`define EPSC_ADDR_W        8
`define EPSC_DATA_W        32
`define EPSC_OFS_PMC       8'h54
`define EPSC_OFS_INTERRUPT_STATUS_REG   8'h58
`define EPSC_OFS_BYTE_TEST 8'h64
`define EPSC_OFS_PHY_CTRL  8'h68
`define EPSC_OFS_PHY_MODE  8'h6C

`define EPSC_PMC_READY     0
`define EPSC_PMC_PME_EN    1
`define EPSC_PMC_PULSE_SEL 2
`define EPSC_PMC_WAKEUP_STATUS_FIELD_LO   4
`define EPSC_PMC_WAKE_FRAME_DETECT_ENABLE    8
`define EPSC_PMC_ENERGY_WAKE_ENABLE     9
`define EPSC_PMC_PSEL_LO   12
`define EPSC_INT_PME       1
`define EPSC_PHY_PWRDN     11
`define EPSC_PHY_EDPD      13

`define EPSC_PSEL_NORMAL   2'h0
`define EPSC_PSEL_WOL      2'h1
`define EPSC_PSEL_ED       2'h2
`define EPSC_WAKEUP_STATUS_FIELD_NONE     2'h0
`define EPSC_WAKEUP_STATUS_FIELD_ENERGY   2'h1
`define EPSC_WAKEUP_STATUS_FIELD_FRAME    2'h2
`define EPSC_BYTE_TEST_VAL 32'h5AC3_3CA5

`define EPSC_CLK_MHZ       250
`define EPSC_RESUME_MS     2
`define EPSC_PULSE_MS      50
`define EPSC_RESUME_CYC    (`EPSC_RESUME_MS * 1000 * `EPSC_CLK_MHZ)
`define EPSC_PULSE_CYC     (`EPSC_PULSE_MS * 1000 * `EPSC_CLK_MHZ)
`define EPSC_TMR_W         24

`endif

// ---- pkg/epsc_pkg.sv ----
// Types shared by the power-state block.
// Assumes nothing beyond a SystemVerilog compiler.
package epsc_pkg;

    typedef enum logic [1:0] {
        ST_NORMAL = 2'b00,
        ST_WOL    = 2'b01,
        ST_ED     = 2'b10,
        ST_RESUME = 2'b11
    } epsc_state_type;

endpackage : epsc_pkg

// ---- design/epsc_timer.sv ----
// Load-and-count-down timer used for the event pulse and the resume delay.
// Assumes a single clock and an asynchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module epsc_timer #(
    parameter int WIDTH = 24
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             start,
    input  wire logic             stop,
    input  wire logic [WIDTH-1:0] count,
    output var  logic             busy,
    output var  logic             done
);

    logic [WIDTH-1:0] cnt_q;

    // --------------------------------------------------------------
    // Counter: start reloads, stop abandons, otherwise count down.
    // --------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (start) begin
            cnt_q <= count;
        end else if (stop) begin
            cnt_q <= '0;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - WIDTH'(1);
        end
    end

    assign busy = (cnt_q != '0);
    assign done = (cnt_q == WIDTH'(1)) && !start && !stop;

endmodule : epsc_timer
`default_nettype wire

// ---- design/epsc_power_ctrl.sv ----
// Power-state controller: normal state, wake-on-LAN sleep, energy-detect sleep.
// Assumes a host on a strobe register port, synchronous inputs and one clock.
//
// How it works
// - Exactly one normal and two sleep states.
// - Ready clears in sleep, sets on return.
// - Writes ignored until one read is seen.
// - Byte-test write in sleep wakes device.
// - Wake write resets state select to normal.
// - Code 01 enters wake-on-LAN sleep, clocks gated.
// - Wake frame sets status 10, drives event.
// - Energy sleep stops MAC, host, internal clocks.
// - Carrier in energy sleep sets status 01.
// - Interrupt flag sets regardless of output enable.
// - Source holds; flag cleared by one afterwards.
// - Interrupt independent of event pin and enable.
// - Pulse mode drives event pin 50 ms.
// - Static mode holds event pin until cleared.
// - Pin drops on status, enable or output clear.
// - Wakeup status readable while asleep.
// - PHY power-down bit holds PHY down, resets after.
// - Registers keep contents through sleep.
// - Ready sets within 2 ms of wake.
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "epsc_params.svh"
module epsc_power_ctrl #(
    parameter int RESUME_CYC = `EPSC_RESUME_CYC,
    parameter int PULSE_CYC  = `EPSC_PULSE_CYC
) (
    input  wire logic                    mclk,
    input  wire logic                    rst,
    input  wire logic [`EPSC_ADDR_W-1:0] reg_addr,
    input  wire logic [`EPSC_DATA_W-1:0] reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output var  logic [`EPSC_DATA_W-1:0] reg_rdata,
    input  wire logic                    wake_frame_det,
    input  wire logic                    carrier_present,
    output var  logic                    pme_out,
    output var  logic                    pme_irq_src,
    output var  logic                    ready_out,
    output var  logic                    mac_clk_en,
    output var  logic                    host_clk_en,
    output var  logic                    pm_clk_en,
    output var  logic                    int_clk_en,
    output var  logic                    phy_clk_en,
    output var  logic                    phy_power_down,
    output var  logic                    phy_energy_pd,
    output var  logic                    phy_reset
);

    localparam int TW = `EPSC_TMR_W;

    epsc_pkg::epsc_state_type state_q;
    logic [1:0]              psel_q;
    logic [1:0]              wakeup_status_field_q;
    logic [1:0]              wakeup_status_field_d;
    logic                    ready_q;
    logic                    read_seen_q;
    logic                    pme_en_q;
    logic                    pulse_sel_q;
    logic                    wake_frame_detect_enable_q;
    logic                    energy_wake_enable_q;
    logic                    int_flag_q;
    logic                    phy_pd_q;
    logic                    phy_ed_q;
    logic                    phy_rst_q;
    logic                    pme_src_q;
    logic                    pme_q;
    logic [`EPSC_DATA_W-1:0] rdata_q;
    logic                    mac_en_q;
    logic                    host_en_q;
    logic                    pm_en_q;
    logic                    int_en_q;
    logic                    phy_en_q;
    logic                    asleep;
    logic                    wr_ok;
    logic                    wake_wr;
    logic                    pmc_wr;
    logic                    int_wr;
    logic [1:0]              wr_psel;
    logic                    det_wol;
    logic                    det_ed;
    logic                    pme_src;
    logic                    pulse_busy;
    logic                    resume_done;

    // ------------------------------------------------------------------
    // Write decode.
    // ------------------------------------------------------------------
    assign asleep  = (state_q == epsc_pkg::ST_WOL) || (state_q == epsc_pkg::ST_ED);
    assign wr_ok   = reg_wr && ready_q && read_seen_q;
    assign wake_wr = reg_wr && asleep && (reg_addr == `EPSC_OFS_BYTE_TEST);
    assign pmc_wr  = wr_ok && (reg_addr == `EPSC_OFS_PMC);
    assign int_wr  = wr_ok && (reg_addr == `EPSC_OFS_INTERRUPT_STATUS_REG);
    assign wr_psel = reg_wdata[`EPSC_PMC_PSEL_LO +: 2];

    // ------------------------------------------------------------------
    // Power state sequence.
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= epsc_pkg::ST_NORMAL;
        end else begin
            unique case (state_q)
                epsc_pkg::ST_NORMAL: begin
                    if (pmc_wr && wr_psel == `EPSC_PSEL_WOL) begin
                        state_q <= epsc_pkg::ST_WOL;
                    end else if (pmc_wr && wr_psel == `EPSC_PSEL_ED) begin
                        state_q <= epsc_pkg::ST_ED;
                    end
                end
                epsc_pkg::ST_WOL, epsc_pkg::ST_ED: begin
                    if (wake_wr) begin
                        state_q <= epsc_pkg::ST_RESUME;
                    end
                end
                epsc_pkg::ST_RESUME: begin
                    if (resume_done) begin
                        state_q <= epsc_pkg::ST_NORMAL;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Resume delay before ready returns.
    // ------------------------------------------------------------------
    epsc_timer #(
        .WIDTH (TW)
    ) u_resume (
        .mclk  (mclk),
        .rst   (rst),
        .start (wake_wr),
        .stop  (1'b0),
        .count (TW'(RESUME_CYC)),
        .busy  (),
        .done  (resume_done)
    );

    // ------------------------------------------------------------------
    // State select field, ready flag and first-read lock.
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            psel_q <= `EPSC_PSEL_NORMAL;
        end else if (wake_wr) begin
            psel_q <= `EPSC_PSEL_NORMAL;
        end else if (pmc_wr && state_q == epsc_pkg::ST_NORMAL &&
                     (wr_psel == `EPSC_PSEL_WOL || wr_psel == `EPSC_PSEL_ED)) begin
            psel_q <= wr_psel;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ready_q <= 1'b1;
        end else if (pmc_wr && (wr_psel == `EPSC_PSEL_WOL || wr_psel == `EPSC_PSEL_ED)) begin
            ready_q <= 1'b0;
        end else if (resume_done) begin
            ready_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            read_seen_q <= 1'b0;
        end else if (resume_done) begin
            read_seen_q <= 1'b0;
        end else if (reg_rd) begin
            read_seen_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Enables in the control register, kept through sleep.
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pme_en_q    <= 1'b0;
            pulse_sel_q <= 1'b0;
            wake_frame_detect_enable_q    <= 1'b0;
            energy_wake_enable_q     <= 1'b0;
        end else if (pmc_wr) begin
            pme_en_q    <= reg_wdata[`EPSC_PMC_PME_EN];
            pulse_sel_q <= reg_wdata[`EPSC_PMC_PULSE_SEL];
            wake_frame_detect_enable_q    <= reg_wdata[`EPSC_PMC_WAKE_FRAME_DETECT_ENABLE];
            energy_wake_enable_q     <= reg_wdata[`EPSC_PMC_ENERGY_WAKE_ENABLE];
        end
    end

    // ------------------------------------------------------------------
    // Wake detection and wakeup status.
    // ------------------------------------------------------------------
    assign det_wol = (state_q == epsc_pkg::ST_WOL) && wake_frame_det;
    assign det_ed  = (state_q == epsc_pkg::ST_ED) && carrier_present;

    always_comb begin
        wakeup_status_field_d = wakeup_status_field_q;
        if (pmc_wr) begin
            wakeup_status_field_d = wakeup_status_field_q & ~reg_wdata[`EPSC_PMC_WAKEUP_STATUS_FIELD_LO +: 2];
        end
        if (det_wol) begin
            wakeup_status_field_d = `EPSC_WAKEUP_STATUS_FIELD_FRAME;
        end else if (det_ed) begin
            wakeup_status_field_d = `EPSC_WAKEUP_STATUS_FIELD_ENERGY;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wakeup_status_field_q <= `EPSC_WAKEUP_STATUS_FIELD_NONE;
        end else begin
            wakeup_status_field_q <= wakeup_status_field_d;
        end
    end

    // ------------------------------------------------------------------
    // Internal event source and interrupt status flag.
    // ------------------------------------------------------------------
    assign pme_src = (wakeup_status_field_q[1] && wake_frame_detect_enable_q) || (wakeup_status_field_q[0] && energy_wake_enable_q);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pme_src_q <= 1'b0;
        end else begin
            pme_src_q <= pme_src;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            int_flag_q <= 1'b0;
        end else if (pme_src) begin
            int_flag_q <= 1'b1;
        end else if (int_wr && reg_wdata[`EPSC_INT_PME]) begin
            int_flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // External event pin, pulsed or static.
    // ------------------------------------------------------------------
    epsc_timer #(
        .WIDTH (TW)
    ) u_pulse (
        .mclk  (mclk),
        .rst   (rst),
        .start (pme_src && !pme_src_q),
        .stop  (!pme_src),
        .count (TW'(PULSE_CYC)),
        .busy  (pulse_busy),
        .done  ()
    );

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pme_q <= 1'b0;
        end else if (!pme_en_q || !pme_src) begin
            pme_q <= 1'b0;
        end else if (pulse_sel_q) begin
            pme_q <= pulse_busy;
        end else begin
            pme_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // PHY control bits.
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            phy_pd_q  <= 1'b0;
            phy_ed_q  <= 1'b0;
            phy_rst_q <= 1'b0;
        end else begin
            phy_rst_q <= 1'b0;
            if (wr_ok && reg_addr == `EPSC_OFS_PHY_CTRL) begin
                phy_pd_q  <= reg_wdata[`EPSC_PHY_PWRDN];
                phy_rst_q <= phy_pd_q && !reg_wdata[`EPSC_PHY_PWRDN];
            end
            if (wr_ok && reg_addr == `EPSC_OFS_PHY_MODE) begin
                phy_ed_q <= reg_wdata[`EPSC_PHY_EDPD];
            end
        end
    end

    // ------------------------------------------------------------------
    // Clock gating per power state.
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mac_en_q  <= 1'b1;
            host_en_q <= 1'b1;
            pm_en_q   <= 1'b1;
            int_en_q  <= 1'b1;
            phy_en_q  <= 1'b1;
        end else begin
            mac_en_q  <= !asleep;
            host_en_q <= !asleep;
            pm_en_q   <= (state_q != epsc_pkg::ST_ED);
            int_en_q  <= (state_q != epsc_pkg::ST_ED);
            phy_en_q  <= (state_q != epsc_pkg::ST_ED) || !phy_ed_q;
        end
    end

    // ------------------------------------------------------------------
    // Read port, data valid in the cycle after the strobe.
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= '0;
            if (reg_rd) begin
                unique case (reg_addr)
                    `EPSC_OFS_PMC: begin
                        rdata_q[`EPSC_PMC_READY]          <= ready_q;
                        rdata_q[`EPSC_PMC_PME_EN]         <= pme_en_q;
                        rdata_q[`EPSC_PMC_PULSE_SEL]      <= pulse_sel_q;
                        rdata_q[`EPSC_PMC_WAKEUP_STATUS_FIELD_LO +: 2]   <= wakeup_status_field_q;
                        rdata_q[`EPSC_PMC_WAKE_FRAME_DETECT_ENABLE]         <= wake_frame_detect_enable_q;
                        rdata_q[`EPSC_PMC_ENERGY_WAKE_ENABLE]          <= energy_wake_enable_q;
                        rdata_q[`EPSC_PMC_PSEL_LO +: 2]   <= psel_q;
                    end
                    `EPSC_OFS_INTERRUPT_STATUS_REG: begin
                        rdata_q[`EPSC_INT_PME] <= int_flag_q;
                    end
                    `EPSC_OFS_BYTE_TEST: begin
                        rdata_q <= `EPSC_BYTE_TEST_VAL;
                    end
                    `EPSC_OFS_PHY_CTRL: begin
                        rdata_q[`EPSC_PHY_PWRDN] <= phy_pd_q;
                    end
                    `EPSC_OFS_PHY_MODE: begin
                        rdata_q[`EPSC_PHY_EDPD] <= phy_ed_q;
                    end
                    default: begin
                        rdata_q <= '0;
                    end
                endcase
            end
        end
    end

    assign reg_rdata      = rdata_q;
    assign pme_out        = pme_q;
    assign pme_irq_src    = pme_src_q;
    assign ready_out      = ready_q;
    assign mac_clk_en     = mac_en_q;
    assign host_clk_en    = host_en_q;
    assign pm_clk_en      = pm_en_q;
    assign int_clk_en     = int_en_q;
    assign phy_clk_en     = phy_en_q;
    assign phy_power_down = phy_pd_q;
    assign phy_energy_pd  = phy_ed_q;
    assign phy_reset      = phy_rst_q;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    a_ready_sleep : assert property (@(posedge mclk) disable iff (rst)
        asleep |-> !ready_q)
        else $error("ready set while asleep");

    a_wake_state : assert property (@(posedge mclk) disable iff (rst)
        wake_wr |=> state_q == epsc_pkg::ST_RESUME ##1 !ready_q)
        else $error("wake write did not start resume");

    a_wake_select : assert property (@(posedge mclk) disable iff (rst)
        wake_wr |=> psel_q == `EPSC_PSEL_NORMAL)
        else $error("wake write left select field");

    a_wol_enter : assert property (@(posedge mclk) disable iff (rst)
        (pmc_wr && state_q == epsc_pkg::ST_NORMAL && wr_psel == `EPSC_PSEL_WOL)
        |=> state_q == epsc_pkg::ST_WOL ##1 (!host_en_q && !mac_en_q && int_en_q && pm_en_q))
        else $error("wake-on-LAN entry or gating wrong");

    a_ed_clocks : assert property (@(posedge mclk) disable iff (rst)
        (state_q == epsc_pkg::ST_ED) |=> (!mac_en_q && !host_en_q && !int_en_q && !pm_en_q))
        else $error("energy sleep left a clock on");

    a_frame_status : assert property (@(posedge mclk) disable iff (rst)
        det_wol |=> wakeup_status_field_q == `EPSC_WAKEUP_STATUS_FIELD_FRAME)
        else $error("frame wake status wrong");

    a_energy_status : assert property (@(posedge mclk) disable iff (rst)
        det_ed |=> wakeup_status_field_q == `EPSC_WAKEUP_STATUS_FIELD_ENERGY)
        else $error("energy wake status wrong");

    a_flag_set : assert property (@(posedge mclk) disable iff (rst)
        pme_src |=> int_flag_q ##1 (int_flag_q || $past(int_wr)))
        else $error("interrupt flag not held by source");

    a_pin_static : assert property (@(posedge mclk) disable iff (rst)
        (pme_src && pme_en_q && !pulse_sel_q) |=> pme_q)
        else $error("static event pin not driven");

    a_pin_off : assert property (@(posedge mclk) disable iff (rst)
        (!pme_en_q || !pme_src) |=> !pme_q)
        else $error("event pin not released");

    a_first_read : assert property (@(posedge mclk) disable iff (rst)
        (reg_wr && !read_seen_q && reg_addr == `EPSC_OFS_PMC) |=>
        $stable(state_q) && $stable(psel_q) && $stable(wake_frame_detect_enable_q))
        else $error("write took effect before first read");

    a_reserved_code : assert property (@(posedge mclk) disable iff (rst)
        (pmc_wr && wr_psel == 2'h3) |=> $stable(state_q))
        else $error("reserved code changed state");

    a_phy_reset : assert property (@(posedge mclk) disable iff (rst)
        $fell(phy_pd_q) |-> phy_rst_q)
        else $error("no PHY reset on power-up");

endmodule : epsc_power_ctrl
`default_nettype wire

// ---- sim/epsc_host_model.sv ----
// Host model: issues one-cycle read and write strobes on the register port.
// Assumes the block samples the port on the rising edge of mclk.
`timescale 1ns/100ps
`default_nettype none
`include "epsc_params.svh"
module epsc_host_model (
    input  wire logic                    mclk,
    output var  logic [`EPSC_ADDR_W-1:0] reg_addr,
    output var  logic [`EPSC_DATA_W-1:0] reg_wdata,
    output var  logic                    reg_wr,
    output var  logic                    reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Released address and data lines show the inverse of the last value.
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : acc
endmodule : epsc_host_model
`default_nettype wire

// ---- sim/epsc_power_ctrl_bench.sv ----
// Testbench of the power-state block: sleep entry, wake events, wake-up, register locks.
// Assumes the host model drives the register port.
`timescale 1ns/100ps
`default_nettype none
`include "epsc_params.svh"
module epsc_power_ctrl_bench;
    localparam int resume_cyc = 20;
    localparam int pulse_cyc  = 30;
    logic        mclk, rst, wake_frame_det, carrier_present, rd_d;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic        reg_wr, reg_rd, pme_out, pme_irq_src, ready_out, phy_reset;
    logic        mac_clk_en, host_clk_en, pm_clk_en, int_clk_en, phy_clk_en, phy_power_down, phy_energy_pd;
    logic [31:0] exp_q[$];
    logic [31:0] en_t[3] = '{32'h102, 32'h206, 32'h100};
    logic [31:0] code_t[3] = '{32'h1, 32'h2, 32'h1};
    logic [31:0] wakeup_status_field_t[3] = '{32'h2, 32'h1, 32'h2};
    int          fail_count = 0;
    int          compares = 0;
    int          seed = 32'h587d;
    int          n;

    epsc_host_model u_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd));
    epsc_power_ctrl #(.RESUME_CYC(resume_cyc), .PULSE_CYC(pulse_cyc)) dut (.mclk(mclk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .wake_frame_det(wake_frame_det), .carrier_present(carrier_present), .pme_out(pme_out),
        .pme_irq_src(pme_irq_src), .ready_out(ready_out), .mac_clk_en(mac_clk_en), .host_clk_en(host_clk_en),
        .pm_clk_en(pm_clk_en), .int_clk_en(int_clk_en), .phy_clk_en(phy_clk_en),
        .phy_power_down(phy_power_down), .phy_energy_pd(phy_energy_pd), .phy_reset(phy_reset));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task complete_run;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    task tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : tick

    task wr(input logic [7:0] a, input logic [31:0] d);
        u_host.acc(1'b1, a, d);
    endtask : wr

    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        u_host.acc(1'b0, a, 32'h0);
    endtask : rd_chk

    // ------------------------------------------------------------
    // Read data watcher
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        if (rd_d)
            check(reg_rdata, exp_q.pop_front());
        rd_d <= reg_rd;
    end

    // ------------------------------------------------------------
    // One sleep and wake sequence per table entry
    // ------------------------------------------------------------
    task sleep_run(input int m);
        logic [31:0] c;
        c = en_t[m] | (code_t[m] << 12);
        carrier_present <= (m == 1);
        rd_chk(`EPSC_OFS_PMC, 32'h1);
        if (m == 1)
            wr(`EPSC_OFS_PHY_MODE, 32'h2000);
        wr(`EPSC_OFS_PMC, en_t[m]);
        rd_chk(`EPSC_OFS_PMC, en_t[m] | 32'h1);
        wr(`EPSC_OFS_PMC, c);
        tick(4);
        check(ready_out, 0);
        check({host_clk_en, mac_clk_en}, 2'b00);
        check({pm_clk_en, int_clk_en, phy_clk_en}, (m == 1) ? 3'b000 : 3'b111);
        check(phy_energy_pd, m == 1);
        wr(`EPSC_OFS_PMC, 32'h0);
        if (m != 1) begin
            @(posedge mclk) wake_frame_det <= 1'b1;
            @(posedge mclk) wake_frame_det <= 1'b0;
        end
        tick(3);
        check(pme_irq_src, 1);
        n = 0;
        repeat (pulse_cyc + 10) begin
            @(posedge mclk);
            n += pme_out;
        end
        if (m == 1)
            check(n >= pulse_cyc - 10 && n <= pulse_cyc - 2, 1);
        else if (m == 0)
            check(n, pulse_cyc + 10);
        else
            check(n, 0);
        rd_chk(`EPSC_OFS_PMC, c | (wakeup_status_field_t[m] << 4));
        wr(`EPSC_OFS_BYTE_TEST, $random(seed));
        n = 0;
        while (ready_out !== 1'b1 && n < resume_cyc + 10) begin
            @(posedge mclk);
            n++;
        end
        check(n >= resume_cyc - 2 && n <= resume_cyc + 2, 1);
        tick(1);
        check({host_clk_en, mac_clk_en, int_clk_en}, 3'b111);
        wr(`EPSC_OFS_PMC, 32'h0);
        rd_chk(`EPSC_OFS_PMC, en_t[m] | (wakeup_status_field_t[m] << 4) | 32'h1);
        carrier_present <= 1'b0;
        if (m == 1)
            wr(`EPSC_OFS_PHY_MODE, 32'h0);
        wr(`EPSC_OFS_PMC, en_t[m] | 32'h30);
        tick(3);
        check({pme_out, pme_irq_src}, 2'b00);
        rd_chk(`EPSC_OFS_INTERRUPT_STATUS_REG, 32'h2);
        wr(`EPSC_OFS_INTERRUPT_STATUS_REG, 32'h2);
        rd_chk(`EPSC_OFS_INTERRUPT_STATUS_REG, 32'h0);
        wr(`EPSC_OFS_PMC, 32'h0);
        $display("sleep test %0d done", m);
    endtask : sleep_run

    initial begin
        rst = 1'b1;
        rd_d = 1'b0;
        wake_frame_det = 1'b0;
        carrier_present = 1'b0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        tick(1);
        check({ready_out, host_clk_en, pme_out}, 3'b110);
        wr(`EPSC_OFS_PMC, 32'h102);
        rd_chk(`EPSC_OFS_PMC, 32'h1);
        rd_chk(8'h10, 32'h0);
        rd_chk(`EPSC_OFS_BYTE_TEST, `EPSC_BYTE_TEST_VAL);
        $display("reset test done");
        for (int m = 0; m < 3; m++)
            sleep_run(m);
        wr(`EPSC_OFS_PMC, 32'h3000);
        tick(3);
        check(ready_out, 1);
        rd_chk(`EPSC_OFS_PMC, 32'h1);
        wr(`EPSC_OFS_PHY_CTRL, 32'h800);
        tick(2);
        check(phy_power_down, 1);
        wr(`EPSC_OFS_PHY_CTRL, 32'h0);
        n = 0;
        while (phy_reset !== 1'b1 && n < 4) begin
            @(posedge mclk);
            n++;
        end
        check(n < 4, 1);
        $display("phy and reserved code test done");
        tick(4);
        complete_run;
    end

    initial begin
        #(4 * 20000);
        fail_count++;
        complete_run;
    end
endmodule : epsc_power_ctrl_bench
`default_nettype wire
